// [design/ldc_defs.svh]
// Offsets, field positions, reset values for the logical device config bank.
// Assumes inclusion by bare name from the design module.
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH
`define LDC_BANK_PP 8'h01
`define LDC_BANK_SP2 8'h02
`define LDC_IDX_ACTIVATE 8'h30
`define LDC_IDX_BASE_HIGH 8'h60
`define LDC_IDX_BASE_LOW 8'h61
`define LDC_IDX_IRQ_NUM 8'h70
`define LDC_IDX_IRQ_TYPE 8'h71
`define LDC_IDX_RX_DMA 8'h74
`define LDC_IDX_TX_DMA 8'h75
`define LDC_IDX_DEV_CFG 8'hf0
`define LDC_PP_CFG_RST 8'hf2
`define LDC_SP2_CFG_RST 8'h02
`define LDC_SP2_ACT_RST 8'h00
`define LDC_SP2_BASEH_RST 8'h02
`define LDC_SP2_BASEL_RST 8'hf8
`define LDC_SP2_IRQN_RST 8'h03
`define LDC_SP2_IRQT_RST 8'h03
`define LDC_SP2_DMA_RST 8'h04
`define LDC_BASEH_MASK 8'h07
`define LDC_BASEL_MASK 8'hf8
`define LDC_IRQT_WMASK 8'h02
`define LDC_PP_CFG_WMASK 8'h13
`define LDC_PP_CFG_FIXED 8'he0
`define LDC_SP2_CFG_WMASK 8'h83
`define LDC_BIT_TRISTATE 0
`define LDC_BIT_POWER 1
`define LDC_BIT_BUSY 2
`define LDC_BIT_EXT_ACCESS 4
`define LDC_BIT_BANK_EN 7
`define LDC_GC1_ENABLE_BIT 0
`define LDC_GC6_SP2_BIT 2
`define LDC_PP_EXT_FIRST 12'h403
`define LDC_PP_EXT_LAST 12'h405
`endif

// [design/ldc_pkg.sv]
// Types shared by the logical device configuration bank.
// Assumes the defs header supplies all numeric constants.
package ldc_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ldc_bus_s;
endpackage : ldc_pkg

// [design/ldc_regs.sv]
// Configuration registers of the parallel port device and second serial port.
// Assumes a one-cycle strobe register port; address bits 15:8 select the device,
// 7:0 the configuration index. Device state inputs arrive asynchronously; offset and access lines are same-clock.
`timescale 1ns/10ps
`include "ldc_defs.svh"

// What this block does
// - Reset loads parallel device config with f2h.
// - Extended access clear blocks port offsets 403h to 405h.
// - Extended access set serves the three extended port registers.
// - Parallel power bit clear stops the port clock, keeping registers.
// - Parallel power bit set keeps the port clock running while the device is active.
// - Tristate bit set and device inactive floats that device's outputs.
// - Reset loads second serial port config with 02h.
// - Bank enable clear blocks serial extended register accesses.
// - Bank enable set allows serial bank switching.
// - Serial config bit 2 reads busy, read only.
// - Serial power clear stops clock, defaults outputs, ring still interrupts.
// - Serial power set keeps serial clock enabled while active.
// - Infrared transmit is driven low whenever the serial port is inactive.
// - Activate resets 00h; bit 0 gated by global config bits.
// - Base high resets 02h; bits 7 to 3 read zero.
// - Base low resets f8h; bits 2 to 0 read zero.
// - Interrupt number register resets 03h.
// - Interrupt type resets 03h; only bit 1 writable.
// - Receive and transmit DMA selects reset 04h, writable.
// - Extended parallel registers serve only the extended ECP mode.
module ldc_regs
#(
  parameter int OFFSET_WIDTH = 12
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [15:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic [7:0] global_config_one_in,
  input wire logic [7:0] global_config_six_in,
  input wire logic parallel_port_device_active_in,
  input wire logic parallel_ecp_extended_mode_in,
  input wire logic [OFFSET_WIDTH-1:0] parallel_port_offset_in,
  input wire logic parallel_port_access_in,
  input wire logic second_serial_port_ext_access_in,
  input wire logic second_serial_port_busy_in,
  input wire logic ring_indicate_input_in,
  input wire logic infrared_transmit_in,
  output logic parallel_port_clock_en_out,
  output logic parallel_ext_decode_out,
  output logic parallel_outputs_float_out,
  output logic second_serial_port_active_out,
  output logic second_serial_port_clock_en_out,
  output logic second_serial_port_outputs_default_out,
  output logic second_serial_port_outputs_float_out,
  output logic second_serial_port_ext_decode_out,
  output logic ring_indicate_wake_out,
  output logic infrared_transmit_output_out,
  output logic infrared_transmit_output_oe_out,
  output logic [15:0] second_serial_port_base_out,
  output logic [7:0] second_serial_port_irq_number_out,
  output logic [7:0] second_serial_port_irq_type_out,
  output logic [7:0] second_serial_port_rx_dma_out,
  output logic [7:0] second_serial_port_tx_dma_out
);

  ldc_pkg::ldc_bus_s bus;
  logic [7:0] parallel_device_config;
  logic [7:0] serial2_activate;
  logic [7:0] serial2_base_high;
  logic [7:0] serial2_base_low;
  logic [7:0] serial2_irq_number;
  logic [7:0] serial2_irq_type;
  logic [7:0] serial2_rx_dma_select;
  logic [7:0] serial2_tx_dma_select;
  logic [7:0] serial2_device_config;
  logic [7:0] next_rdata;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic busy_s;
  logic ri_s;
  logic pp_act_s;
  logic ecp_s;
  logic serial_active;
  logic ext_range;
  logic pp_cfg_wr;
  logic sp2_wr;

  // Offsets narrower than 11 bits cannot reach the extended registers
  if (OFFSET_WIDTH < 11)
  begin : g_bad_offset_width
    $error("ldc_regs: OFFSET_WIDTH must be at least 11");
  end

  // Write data masked so read-only bits keep their value
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] wmask);
    merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction : merge

  function automatic logic hit(input logic [15:0] a, input logic [7:0] bank,
                               input logic [7:0] idx);
    hit = (a[15:8] == bank) && (a[7:0] == idx);
  endfunction : hit

  assign bus = '{addr: cfg_addr_in, wdata: cfg_wdata_in, wr: cfg_wr_in, rd: cfg_rd_in};

  // Device state lines are asynchronous; two stages before use
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= {second_serial_port_busy_in, ring_indicate_input_in,
                 parallel_port_device_active_in, parallel_ecp_extended_mode_in};
      sync_b <= sync_a;
    end
  end
  assign busy_s = sync_b[3];
  assign ri_s = sync_b[2];
  assign pp_act_s = sync_b[1];
  assign ecp_s = sync_b[0];

  // All three enables must agree before the port may run
  assign serial_active = serial2_activate[0]
    & global_config_one_in[`LDC_GC1_ENABLE_BIT]
    & global_config_six_in[`LDC_GC6_SP2_BIT];

  // Offset and access are same-clock; only the mode line needs synchronising
  assign ext_range = (parallel_port_offset_in >= OFFSET_WIDTH'(`LDC_PP_EXT_FIRST))
    && (parallel_port_offset_in <= OFFSET_WIDTH'(`LDC_PP_EXT_LAST));

  // Write strobes per device bank
  assign pp_cfg_wr = bus.wr && hit(bus.addr, `LDC_BANK_PP, `LDC_IDX_DEV_CFG);
  assign sp2_wr = bus.wr && (bus.addr[15:8] == `LDC_BANK_SP2);

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      parallel_device_config <= `LDC_PP_CFG_RST;
    else if (pp_cfg_wr)
      // Upper three held at one even if software slips
      parallel_device_config <= merge(parallel_device_config, bus.wdata, `LDC_PP_CFG_WMASK)
        | `LDC_PP_CFG_FIXED;
  end

  // Serial register groups; the busy bit is never stored, the read path inserts it
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      serial2_activate <= `LDC_SP2_ACT_RST;
    else if (sp2_wr && bus.addr[7:0] == `LDC_IDX_ACTIVATE)
      serial2_activate <= {7'h00, bus.wdata[0]};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      serial2_base_high <= `LDC_SP2_BASEH_RST;
      serial2_base_low <= `LDC_SP2_BASEL_RST;
    end
    else if (sp2_wr)
    begin
      if (bus.addr[7:0] == `LDC_IDX_BASE_HIGH)
        serial2_base_high <= bus.wdata & `LDC_BASEH_MASK;
      else if (bus.addr[7:0] == `LDC_IDX_BASE_LOW)
        serial2_base_low <= bus.wdata & `LDC_BASEL_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      serial2_irq_number <= `LDC_SP2_IRQN_RST;
      serial2_irq_type <= `LDC_SP2_IRQT_RST;
    end
    else if (sp2_wr)
    begin
      if (bus.addr[7:0] == `LDC_IDX_IRQ_NUM)
        serial2_irq_number <= bus.wdata;
      else if (bus.addr[7:0] == `LDC_IDX_IRQ_TYPE)
        serial2_irq_type <= merge(serial2_irq_type, bus.wdata, `LDC_IRQT_WMASK);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      serial2_rx_dma_select <= `LDC_SP2_DMA_RST;
      serial2_tx_dma_select <= `LDC_SP2_DMA_RST;
    end
    else if (sp2_wr)
    begin
      if (bus.addr[7:0] == `LDC_IDX_RX_DMA)
        serial2_rx_dma_select <= bus.wdata;
      else if (bus.addr[7:0] == `LDC_IDX_TX_DMA)
        serial2_tx_dma_select <= bus.wdata;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      serial2_device_config <= `LDC_SP2_CFG_RST;
    else if (sp2_wr && bus.addr[7:0] == `LDC_IDX_DEV_CFG)
      serial2_device_config <= merge(serial2_device_config, bus.wdata,
                                     `LDC_SP2_CFG_WMASK);
  end

  // Read mux; unmapped indices read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (hit(bus.addr, `LDC_BANK_PP, `LDC_IDX_DEV_CFG))
      next_rdata = parallel_device_config;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_ACTIVATE))
      next_rdata = serial2_activate;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_BASE_HIGH))
      next_rdata = serial2_base_high;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_BASE_LOW))
      next_rdata = serial2_base_low;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_IRQ_NUM))
      next_rdata = serial2_irq_number;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_IRQ_TYPE))
      next_rdata = serial2_irq_type;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_RX_DMA))
      next_rdata = serial2_rx_dma_select;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_TX_DMA))
      next_rdata = serial2_tx_dma_select;
    else if (hit(bus.addr, `LDC_BANK_SP2, `LDC_IDX_DEV_CFG))
    begin
      next_rdata = serial2_device_config;
      next_rdata[`LDC_BIT_BUSY] = busy_s;
    end
  end

  // Read data stands one cycle only, then falls back to zero
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      cfg_rdata_out <= 8'h00;
    else if (bus.rd)
      cfg_rdata_out <= next_rdata;
    else
      cfg_rdata_out <= 8'h00;
  end

  // Parallel port control outputs
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      parallel_port_clock_en_out <= 1'b0;
      parallel_ext_decode_out <= 1'b0;
      parallel_outputs_float_out <= 1'b0;
    end
    else
    begin
      // Clock gating only; register contents are untouched
      parallel_port_clock_en_out <= pp_act_s & parallel_device_config[`LDC_BIT_POWER];
      // Blocked accesses simply never reach the port
      parallel_ext_decode_out <= parallel_port_access_in & ext_range & ecp_s
        & parallel_device_config[`LDC_BIT_EXT_ACCESS];
      parallel_outputs_float_out <= ~pp_act_s
        & parallel_device_config[`LDC_BIT_TRISTATE];
    end
  end

  // Second serial port state outputs
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      second_serial_port_active_out <= 1'b0;
      second_serial_port_clock_en_out <= 1'b0;
      second_serial_port_outputs_default_out <= 1'b1;
      second_serial_port_outputs_float_out <= 1'b0;
      second_serial_port_ext_decode_out <= 1'b0;
    end
    else
    begin
      second_serial_port_active_out <= serial_active;
      second_serial_port_clock_en_out <= serial_active
        & serial2_device_config[`LDC_BIT_POWER];
      second_serial_port_outputs_default_out <= ~serial_active
        | ~serial2_device_config[`LDC_BIT_POWER];
      second_serial_port_outputs_float_out <= ~serial_active
        & serial2_device_config[`LDC_BIT_TRISTATE];
      second_serial_port_ext_decode_out <= second_serial_port_ext_access_in & serial_active
        & serial2_device_config[`LDC_BIT_BANK_EN];
    end
  end

  // Second serial port pin-side outputs
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ring_indicate_wake_out <= 1'b0;
      infrared_transmit_output_out <= 1'b0;
      infrared_transmit_output_oe_out <= 1'b1;
    end
    else
    begin
      // Ring indicate still wakes in low power mode
      ring_indicate_wake_out <= serial_active & ri_s
        & ~serial2_device_config[`LDC_BIT_POWER];
      // Always driven, low when inactive, regardless of tristate bit
      infrared_transmit_output_out <= serial_active & serial2_device_config[`LDC_BIT_POWER]
        & infrared_transmit_in;
      infrared_transmit_output_oe_out <= 1'b1;
    end
  end

  // Copies for the port logic, one cycle behind the bank
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      second_serial_port_base_out <= {`LDC_SP2_BASEH_RST, `LDC_SP2_BASEL_RST};
      second_serial_port_irq_number_out <= `LDC_SP2_IRQN_RST;
      second_serial_port_irq_type_out <= `LDC_SP2_IRQT_RST;
      second_serial_port_rx_dma_out <= `LDC_SP2_DMA_RST;
      second_serial_port_tx_dma_out <= `LDC_SP2_DMA_RST;
    end
    else
    begin
      second_serial_port_base_out <= {serial2_base_high, serial2_base_low};
      second_serial_port_irq_number_out <= serial2_irq_number;
      second_serial_port_irq_type_out <= serial2_irq_type;
      second_serial_port_rx_dma_out <= serial2_rx_dma_select;
      second_serial_port_tx_dma_out <= serial2_tx_dma_select;
    end
  end

endmodule : ldc_regs

// [verif/ldc_regs_chk.sv]
// Assertion checker for the logical device configuration bank.
// Assumes one clock domain and a synchronous active low reset; bound to ldc_regs.
`timescale 1ns/10ps
module ldc_regs_chk
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_rdata_out,
  input wire logic [11:0] parallel_port_offset_in,
  input wire logic parallel_port_access_in,
  input wire logic parallel_ext_decode_out,
  input wire logic second_serial_port_ext_access_in,
  input wire logic second_serial_port_ext_decode_out,
  input wire logic second_serial_port_active_out,
  input wire logic second_serial_port_clock_en_out,
  input wire logic second_serial_port_outputs_default_out,
  input wire logic second_serial_port_outputs_float_out,
  input wire logic ring_indicate_wake_out,
  input wire logic infrared_transmit_output_out,
  input wire logic infrared_transmit_output_oe_out,
  input wire logic [15:0] second_serial_port_base_out,
  input wire logic [7:0] second_serial_port_irq_type_out
);
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_rd_idle;
    !$past(cfg_rd_in) |-> cfg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_pp_dec;
    parallel_ext_decode_out |->
      $past(parallel_port_access_in) && ($past(parallel_port_offset_in) inside {[12'h403:12'h405]});
  endproperty
  a_pp_dec: assert property (p_pp_dec) else $error("parallel decode out of range");
  property p_sp_dec;
    second_serial_port_ext_decode_out |-> $past(second_serial_port_ext_access_in);
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("serial decode without access");
  property p_ir_low;
    !second_serial_port_active_out |-> !infrared_transmit_output_out && infrared_transmit_output_oe_out;
  endproperty
  a_ir_low: assert property (p_ir_low) else $error("infrared not low while inactive");
  property p_clk_act;
    second_serial_port_clock_en_out |-> second_serial_port_active_out;
  endproperty
  a_clk_act: assert property (p_clk_act) else $error("serial clock while inactive");
  property p_dflt;
    !second_serial_port_clock_en_out |-> second_serial_port_outputs_default_out;
  endproperty
  a_dflt: assert property (p_dflt) else $error("outputs not default");
  property p_wake;
    ring_indicate_wake_out |-> !second_serial_port_clock_en_out && second_serial_port_active_out;
  endproperty
  a_wake: assert property (p_wake) else $error("ring wake in normal power");
  property p_float;
    second_serial_port_outputs_float_out |-> !second_serial_port_active_out;
  endproperty
  a_float: assert property (p_float) else $error("serial floated while active");
  property p_base;
    second_serial_port_base_out[15:11] == 5'h00 && second_serial_port_base_out[2:0] == 3'h0;
  endproperty
  a_base: assert property (p_base) else $error("base fixed bits wrong");
  property p_irqt;
    second_serial_port_irq_type_out[0] && second_serial_port_irq_type_out[7:2] == 6'h00;
  endproperty
  a_irqt: assert property (p_irqt) else $error("interrupt type fixed bits wrong");
  c_pp_dec: cover property (parallel_ext_decode_out);
  c_wake: cover property (ring_indicate_wake_out);
  c_ir: cover property (infrared_transmit_output_out);
endmodule : ldc_regs_chk

bind ldc_regs ldc_regs_chk chk_u (.clk_in, .rstn_in, .cfg_rd_in, .cfg_rdata_out,
  .parallel_port_offset_in, .parallel_port_access_in, .parallel_ext_decode_out,
  .second_serial_port_ext_access_in, .second_serial_port_ext_decode_out,
  .second_serial_port_active_out, .second_serial_port_clock_en_out,
  .second_serial_port_outputs_default_out, .second_serial_port_outputs_float_out,
  .ring_indicate_wake_out, .infrared_transmit_output_out, .infrared_transmit_output_oe_out,
  .second_serial_port_base_out, .second_serial_port_irq_type_out);

// [verif/tb.sv]
// Self-checking bench for the logical device configuration bank.
// Assumes the one-cycle strobe register port and registered derived outputs.
`timescale 1ns/10ps
module tb;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] gc1 = 8'h00;
  logic [7:0] gc6 = 8'h00;
  logic pp_act = 1'b0;
  logic ecp = 1'b0;
  logic [11:0] ofs = 12'h000;
  logic pp_acc = 1'b0;
  logic ext_acc = 1'b0;
  logic busy = 1'b0;
  logic ring = 1'b0;
  logic ir_in = 1'b0;
  logic [7:0] rdata;
  logic [15:0] base;
  logic [7:0] irqn, irqt, rxd, txd;
  logic pp_clk, pp_dec, pp_flt, act, sp_clk, sp_dflt, sp_flt, sp_dec, wake, ir, ir_oe;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] ra [9] = '{16'h01f0, 16'h0230, 16'h0260, 16'h0261, 16'h0270, 16'h0271,
    16'h0274, 16'h0275, 16'h02f0};
  logic [7:0] rv [9] = '{8'hf2, 8'h00, 8'h02, 8'hf8, 8'h03, 8'h03, 8'h04, 8'h04, 8'h02};
  logic [7:0] hv [9] = '{8'hf3, 8'h01, 8'h07, 8'hf8, 8'hff, 8'h03, 8'hff, 8'hff, 8'h83};
  logic [7:0] lv [9] = '{8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  ldc_regs dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
    .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_rdata_out(rdata), .global_config_one_in(gc1),
    .global_config_six_in(gc6), .parallel_port_device_active_in(pp_act),
    .parallel_ecp_extended_mode_in(ecp), .parallel_port_offset_in(ofs),
    .parallel_port_access_in(pp_acc), .second_serial_port_ext_access_in(ext_acc),
    .second_serial_port_busy_in(busy), .ring_indicate_input_in(ring),
    .infrared_transmit_in(ir_in), .parallel_port_clock_en_out(pp_clk),
    .parallel_ext_decode_out(pp_dec), .parallel_outputs_float_out(pp_flt),
    .second_serial_port_active_out(act), .second_serial_port_clock_en_out(sp_clk),
    .second_serial_port_outputs_default_out(sp_dflt),
    .second_serial_port_outputs_float_out(sp_flt), .second_serial_port_ext_decode_out(sp_dec),
    .ring_indicate_wake_out(wake), .infrared_transmit_output_out(ir),
    .infrared_transmit_output_oe_out(ir_oe), .second_serial_port_base_out(base),
    .second_serial_port_irq_number_out(irqn), .second_serial_port_irq_type_out(irqt),
    .second_serial_port_rx_dma_out(rxd), .second_serial_port_tx_dma_out(txd));
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    chk(rdata, exp);
  endtask : rd_reg
  task automatic settle;
    repeat (4) @(posedge clk_in);
  endtask : settle
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    #50000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd_reg(ra[i], rv[i]);
    chk(base[15:8], 8'h02);
    chk(base[7:0], 8'hf8);
    chk(irqn, 8'h03);
    chk(irqt, 8'h03);
    chk(rxd, 8'h04);
    chk(txd, 8'h04);
    $display("reset values done");
    wr_reg(16'h0250, 8'hff);
    rd_reg(16'h0250, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(ra[i], 8'hff);
      rd_reg(ra[i], hv[i]);
      wr_reg(ra[i], (i == 0) ? 8'he0 : 8'h00);
      rd_reg(ra[i], lv[i]);
    end
    wr_reg(16'h0270, 8'h0a);
    wr_reg(16'h0274, 8'h05);
    wr_reg(16'h0275, 8'h06);
    settle();
    chk(irqn, 8'h0a);
    chk(rxd, 8'h05);
    chk(txd, 8'h06);
    chk(base[15:8], 8'h00);
    chk(base[7:0], 8'h00);
    chk(irqt, 8'h01);
    $display("access kinds done");
    busy <= 1'b1;
    settle();
    rd_reg(16'h02f0, 8'h04);
    wr_reg(16'h02f0, 8'h02);
    busy <= 1'b0;
    settle();
    rd_reg(16'h02f0, 8'h02);
    $display("busy done");
    wr_reg(16'h0230, 8'h01);
    gc1 <= 8'h01;
    settle();
    chk1(act, 1'b0);
    gc6 <= 8'h04;
    ir_in <= 1'b1;
    ext_acc <= 1'b1;
    settle();
    chk1(act, 1'b1);
    chk1(sp_clk, 1'b1);
    chk1(ir, 1'b1);
    chk1(sp_dec, 1'b0);
    wr_reg(16'h02f0, 8'h82);
    settle();
    chk1(sp_dec, 1'b1);
    ring <= 1'b1;
    wr_reg(16'h02f0, 8'h00);
    settle();
    chk1(sp_clk, 1'b0);
    chk1(sp_dflt, 1'b1);
    chk1(wake, 1'b1);
    rd_reg(16'h0230, 8'h01);
    wr_reg(16'h02f0, 8'h03);
    gc6 <= 8'h00;
    settle();
    chk1(act, 1'b0);
    chk1(ir, 1'b0);
    chk1(ir_oe, 1'b1);
    chk1(sp_flt, 1'b1);
    $display("serial port done");
    pp_act <= 1'b1;
    settle();
    chk1(pp_clk, 1'b0);
    wr_reg(16'h01f0, 8'hf2);
    settle();
    chk1(pp_clk, 1'b1);
    ecp <= 1'b1;
    pp_acc <= 1'b1;
    for (int o = 12'h402; o <= 12'h406; o++)
    begin
      ofs <= o[11:0];
      settle();
      chk1(pp_dec, o >= 12'h403 && o <= 12'h405);
    end
    ofs <= 12'h404;
    ecp <= 1'b0;
    settle();
    chk1(pp_dec, 1'b0);
    ecp <= 1'b1;
    wr_reg(16'h01f0, 8'he2);
    settle();
    chk1(pp_dec, 1'b0);
    wr_reg(16'h01f0, 8'he3);
    pp_act <= 1'b0;
    settle();
    chk1(pp_flt, 1'b1);
    $display("parallel port done");
    stop_test();
  end
endmodule : tb
